// ==== dv/rtr_chk.sv ====
`timescale 1ns/1ps
module rtr_chk (
  input logic REF_CLK,
  input logic RESET,
  input logic RESET_PIN_N,
  input logic WATCHDOG_TIMEOUT,
  input logic SLEEP_LEVEL_TWO,
  input logic SLEEP_LEVEL_THREE,
  input logic SYSTEM_RESET,
  input logic PERIPH_REG_INIT,
  input logic WATCHDOG_ENABLE,
  input logic WATCHDOG_COUNT_CLEAR,
  input logic REGISTERS_RETAINED,
  input logic MEM_ADDR_RETAINED,
  input logic MEM_ADDR_LOST,
  input logic RC_CAL_RESTORE,
  input logic [15:0] MEM_ADDR,
  input logic [15:0] PC_LOAD_VALUE,
  input logic [7:0] PORT_DIR_OUT,
  input logic [7:0] PORT_ONE_PULL_UP,
  input logic [7:0] RC_CAL_VALUE,
  input logic [7:0] RC_CAL_DEFAULT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  wire sl = SLEEP_LEVEL_TWO | SLEEP_LEVEL_THREE;
  wire lost = MEM_ADDR >= 16'hFDA2 && MEM_ADDR <= 16'hFEFF;
  pc_zero_a: assert property (PC_LOAD_VALUE == 16'h0000) else $error("pc");
  pins_a: assert property (PORT_DIR_OUT == 8'h00 && PORT_ONE_PULL_UP == 8'hFC)
    else $error("pins");
  wd_off_a: assert property (SYSTEM_RESET |-> !WATCHDOG_ENABLE && PERIPH_REG_INIT)
    else $error("wd on");
  pin_rst_a: assert property (!RESET_PIN_N [*5] |-> SYSTEM_RESET) else $error("pin");
  wdt_rst_a: assert property ($rose(WATCHDOG_TIMEOUT) |-> ##[1:4] SYSTEM_RESET)
    else $error("wdt");
  wd_clear_a: assert property ($rose(sl) |=> WATCHDOG_COUNT_CLEAR) else $error("clr");
  cal_back_a: assert property ($fell(sl) |=> RC_CAL_RESTORE && RC_CAL_VALUE == RC_CAL_DEFAULT)
    else $error("cal");
  lost_a: assert property (lost ##1 !SYSTEM_RESET |-> MEM_ADDR_LOST) else $error("lost");
  kept_a: assert property (MEM_ADDR >= 16'hF000 && !lost ##1 !SYSTEM_RESET |->
    MEM_ADDR_RETAINED) else $error("kept");
  regs_a: assert property (!SYSTEM_RESET |-> REGISTERS_RETAINED) else $error("regs");
  cover property ($rose(SYSTEM_RESET));
  cover property ($fell(sl));
  cover property (MEM_ADDR_LOST);
endmodule
bind reset_tick_retention_control rtr_chk rtr_chk_i (.*);

// ==== dv/tb_reset_tick_retention_control.sv ====
`timescale 1ns/1ps
module tb_reset_tick_retention_control;
  logic REF_CLK = 0, RESET = 1, RESET_PIN_N = 1, POWER_ON_DETECT_N = 1;
  logic SUPPLY_DROOP_DETECT_N = 1, WATCHDOG_TIMEOUT = 0, SLEEP_LEVEL_TWO = 0;
  logic SLEEP_LEVEL_THREE = 0, TIMER_TICK, SYSTEM_RESET, PERIPH_REG_INIT, WATCHDOG_ENABLE;
  logic WATCHDOG_COUNT_CLEAR, REGISTERS_RETAINED, MEM_ADDR_RETAINED, MEM_ADDR_LOST;
  logic RC_CAL_RESTORE;
  logic [2:0] TIMER_TICK_DIVIDER_SELECT = 0, SYSTEM_CLOCK_DIVIDER_SELECT = 0;
  logic [15:0] MEM_ADDR = 0, PC_LOAD_VALUE;
  logic [7:0] RC_CAL_DEFAULT = 8'h5A, PORT_DIR_OUT, PORT_ONE_PULL_UP, RC_CAL_VALUE;
  int errors = 0, check_count = 0;
  reset_tick_retention_control reset_tick_retention_control_i (
    .REF_CLK(REF_CLK),
    .RESET(RESET),
    .RESET_PIN_N(RESET_PIN_N),
    .POWER_ON_DETECT_N(POWER_ON_DETECT_N),
    .SUPPLY_DROOP_DETECT_N(SUPPLY_DROOP_DETECT_N),
    .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
    .TIMER_TICK_DIVIDER_SELECT(TIMER_TICK_DIVIDER_SELECT),
    .SYSTEM_CLOCK_DIVIDER_SELECT(SYSTEM_CLOCK_DIVIDER_SELECT),
    .SLEEP_LEVEL_TWO(SLEEP_LEVEL_TWO),
    .SLEEP_LEVEL_THREE(SLEEP_LEVEL_THREE),
    .MEM_ADDR(MEM_ADDR),
    .RC_CAL_DEFAULT(RC_CAL_DEFAULT),
    .TIMER_TICK(TIMER_TICK),
    .SYSTEM_RESET(SYSTEM_RESET),
    .PC_LOAD_VALUE(PC_LOAD_VALUE),
    .PERIPH_REG_INIT(PERIPH_REG_INIT),
    .WATCHDOG_ENABLE(WATCHDOG_ENABLE),
    .WATCHDOG_COUNT_CLEAR(WATCHDOG_COUNT_CLEAR),
    .PORT_DIR_OUT(PORT_DIR_OUT),
    .PORT_ONE_PULL_UP(PORT_ONE_PULL_UP),
    .REGISTERS_RETAINED(REGISTERS_RETAINED),
    .MEM_ADDR_RETAINED(MEM_ADDR_RETAINED),
    .MEM_ADDR_LOST(MEM_ADDR_LOST),
    .RC_CAL_RESTORE(RC_CAL_RESTORE),
    .RC_CAL_VALUE(RC_CAL_VALUE)
  );
  initial forever #4 REF_CLK = ~REF_CLK;
  //////////////////////////////////////////////////////////////////////
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wt(int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  // the 256-cycle window spans whole tick periods, so the counter phase after a select change cannot skew the count
  task tick_test(int n, int s, int e);
    int c;
    c = 0;
    @(posedge REF_CLK);
    TIMER_TICK_DIVIDER_SELECT <= n;
    SYSTEM_CLOCK_DIVIDER_SELECT <= s;
    wt(200);
    repeat (256) begin
      @(posedge REF_CLK);
      #1 c += TIMER_TICK;
    end
    chk("ticks", e, c);
    $display("done tick %0d %0d", n, s);
  endtask
  task src_test(int k);
    @(posedge REF_CLK);
    RESET_PIN_N <= k != 0;
    POWER_ON_DETECT_N <= k != 1;
    SUPPLY_DROOP_DETECT_N <= k != 2;
    WATCHDOG_TIMEOUT <= k == 3;
    wt(6);
    #1 chk("rst on", 1, SYSTEM_RESET);
    chk("init", 1, PERIPH_REG_INIT);
    chk("dir", 0, PORT_DIR_OUT);
    @(posedge REF_CLK);
    {RESET_PIN_N, POWER_ON_DETECT_N, SUPPLY_DROOP_DETECT_N, WATCHDOG_TIMEOUT} <= 4'hE;
    wt(6);
    #1 chk("rst off", 0, SYSTEM_RESET);
    chk("wd en", 0, WATCHDOG_ENABLE);
    $display("done source %0d", k);
  endtask
  task sleep_test(int k, logic [7:0] prev, logic [7:0] cal);
    int c, r;
    c = 0;
    r = 0;
    @(posedge REF_CLK);
    SLEEP_LEVEL_TWO <= k == 0;
    SLEEP_LEVEL_THREE <= k == 1;
    RC_CAL_DEFAULT <= cal;
    repeat (4) begin
      @(posedge REF_CLK);
      #1 c += WATCHDOG_COUNT_CLEAR;
    end
    chk("cal hold", prev, RC_CAL_VALUE);
    @(posedge REF_CLK);
    SLEEP_LEVEL_TWO <= 0;
    SLEEP_LEVEL_THREE <= 0;
    repeat (4) begin
      @(posedge REF_CLK);
      #1 r += RC_CAL_RESTORE;
    end
    chk("clear", 1, c);
    chk("restore", 1, r);
    chk("cal", cal, RC_CAL_VALUE);
    $display("done sleep %0d", k);
  endtask
  task mem_test(logic [15:0] a);
    logic l;
    l = a >= 16'hFDA2 && a <= 16'hFEFF;
    @(posedge REF_CLK);
    MEM_ADDR <= a;
    wt(2);
    #1 chk("lost", l, MEM_ADDR_LOST);
    chk("kept", a >= 16'hF000 && !l, MEM_ADDR_RETAINED);
    $display("done mem %h", a);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    wt(8);
    RESET <= 0;
    wt(5);
    #1 chk("pull", 8'hFC, PORT_ONE_PULL_UP);
    chk("dir", 0, PORT_DIR_OUT);
    chk("pc", 0, PC_LOAD_VALUE);
    for (int n = 0; n < 8; n++) tick_test(n, 0, 256 >> n);
    tick_test(0, 3, 32);
    for (int k = 0; k < 4; k++) src_test(k);
    sleep_test(0, 8'h5A, 8'h3C);
    sleep_test(1, 8'h3C, 8'hC3);
    mem_test(16'hEFFF);
    mem_test(16'hF000);
    mem_test(16'hFFFF);
    mem_test(16'hFDA1);
    mem_test(16'hFDA2);
    mem_test(16'hFEFF);
    mem_test(16'hFF00);
    print_verdict;
  end
  initial begin
    #200000;
    errors++;
    print_verdict;
  end
endmodule

// ==== inc/rtr_consts.vh ====
`ifndef RTR_CONSTS_VH
`define RTR_CONSTS_VH
`define TICK_DIV_W 3
`define TICK_CNT_W 7
`define TICK_CNT_ZERO 7'h00
`define TICK_CNT_ONE 7'h01
`define SYNC_PRESET 4'hF
`define TICK_DIV_RESET 3'h0
`define CLK_DIV_RESET 3'h1
`define WDOG_CNT_W 15
`define WDOG_CNT_CLEAR 15'h0000
`define PC_W 16
`define PC_RESET 16'h0000
`define RETAIN_LO 16'hF000
`define RETAIN_HI 16'hFFFF
`define LOST_LO 16'hFDA2
`define LOST_HI 16'hFEFF
`define IO_W 8
`define PORT_ONE_NOPULL 8'h03
`define ALL_PULL 8'hFF
`define ALL_ZERO 8'h00
`define CAL_W 8
`endif

// ==== verilog/reset_tick_retention_control.v ====
`timescale 1ns/1ps
`include "rtr_consts.vh"
// Function
// (R1) one shared tick enable prescales all four peripheral timers.
// (R2) tick rate spans reference divided by 1 up to 128 (26 MHz down to about 0.203 MHz).
// (R3) divider select n gives reference divided by two to the power n.
// (R4) software must not select a tick faster than the system clock divider.
// (R5) data memory 0xF000 to 0xFFFF is kept in sleep levels two and three.
// (R6) data memory 0xFDA2 to 0xFEFF is lost on entering sleep levels two and three.
// (R7) processor, peripheral and radio registers keep values across deep sleep.
// (R8) the watchdog 15-bit counter is cleared on entering deep sleep.
// (R9) the fast RC oscillator calibration returns to default on waking.
// (R10) reset comes from the pin, power-on, supply droop, or watchdog timeout.
// (R11) after reset all pins are inputs with pull-up except port one bits zero and one.
// (R12) after reset the program counter is loaded with 0x0000.
// (R13) after reset peripheral registers take reset values and the watchdog is off.
// (R14) power-on and droop detectors hold reset until supply exceeds both thresholds.
// (R15) the droop detector watches only the 1.8 V core supply.
module reset_tick_retention_control (
  input wire REF_CLK,
  input wire RESET,
  input wire RESET_PIN_N,
  input wire POWER_ON_DETECT_N,
  input wire SUPPLY_DROOP_DETECT_N,
  input wire WATCHDOG_TIMEOUT,
  input wire [`TICK_DIV_W-1:0] TIMER_TICK_DIVIDER_SELECT,
  input wire [`TICK_DIV_W-1:0] SYSTEM_CLOCK_DIVIDER_SELECT,
  input wire SLEEP_LEVEL_TWO,
  input wire SLEEP_LEVEL_THREE,
  input wire [`PC_W-1:0] MEM_ADDR,
  input wire [`CAL_W-1:0] RC_CAL_DEFAULT,
  output wire TIMER_TICK,
  output reg SYSTEM_RESET,
  output reg [`PC_W-1:0] PC_LOAD_VALUE,
  output reg PERIPH_REG_INIT,
  output reg WATCHDOG_ENABLE,
  output reg WATCHDOG_COUNT_CLEAR,
  output reg [`IO_W-1:0] PORT_DIR_OUT,
  output reg [`IO_W-1:0] PORT_ONE_PULL_UP,
  output reg REGISTERS_RETAINED,
  output reg MEM_ADDR_RETAINED,
  output reg MEM_ADDR_LOST,
  output reg RC_CAL_RESTORE,
  output reg [`CAL_W-1:0] RC_CAL_VALUE
);
  ////////////////////////////////////////////////////////////////
  // declarations
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg deep_d;
  wire [3:0] raw_src;
  wire any_reset;
  wire [`TICK_DIV_W-1:0] eff_div;
  wire deep;
  wire deep_entry;
  wire deep_exit;
  wire addr_lost;
  wire addr_kept;
  ////////////////////////////////////////////////////////////////
  // shared decode
  function in_range;
    input [`PC_W-1:0] a;
    input [`PC_W-1:0] lo;
    input [`PC_W-1:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  function [`TICK_DIV_W-1:0] slower_div;
    input [`TICK_DIV_W-1:0] tick_sel;
    input [`TICK_DIV_W-1:0] sys_sel;
    begin
      if (tick_sel < sys_sel) begin
        slower_div = sys_sel;
      end else begin
        slower_div = tick_sel;
      end
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  // pin and detector synchronisers
  // preset high so internal reset outlasts the release
  assign raw_src = {WATCHDOG_TIMEOUT, ~SUPPLY_DROOP_DETECT_N, ~POWER_ON_DETECT_N,
    ~RESET_PIN_N};

  always @(posedge REF_CLK) begin
    if (RESET) begin
      sync1 <= `SYNC_PRESET;
    end else begin
      sync1 <= raw_src;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      sync2 <= `SYNC_PRESET;
    end else begin
      sync2 <= sync1;
    end
  end

  // any source asserts reset; detectors keep it while the supply is low [R10] [R14] [R15]
  assign any_reset = RESET | (|sync2);
  ////////////////////////////////////////////////////////////////
  // timer tick
  // clamped so a tick never outruns the system clock [R4]
  assign eff_div = slower_div(TIMER_TICK_DIVIDER_SELECT, SYSTEM_CLOCK_DIVIDER_SELECT);

  tick_prescaler tick_prescaler_i (
    .REF_CLK(REF_CLK),
    .RESET(any_reset),
    .DIV_SEL(eff_div),
    .TICK(TIMER_TICK)
  ); // [R1] [R2] [R3]
  ////////////////////////////////////////////////////////////////
  // sleep tracking
  assign deep = SLEEP_LEVEL_TWO | SLEEP_LEVEL_THREE;
  assign deep_entry = deep & ~deep_d;
  assign deep_exit = ~deep & deep_d;

  always @(posedge REF_CLK) begin
    if (any_reset) begin
      deep_d <= 1'b0;
    end else begin
      deep_d <= deep;
    end
  end
  ////////////////////////////////////////////////////////////////
  // post-reset state
  always @(posedge REF_CLK) begin
    if (any_reset) begin
      SYSTEM_RESET <= 1'b1;
    end else begin
      SYSTEM_RESET <= 1'b0;
    end
  end

  always @(posedge REF_CLK) begin
    if (any_reset) begin
      PC_LOAD_VALUE <= `PC_RESET; // [R12]
    end else begin
      PC_LOAD_VALUE <= `PC_RESET;
    end
  end

  always @(posedge REF_CLK) begin
    if (any_reset) begin
      PERIPH_REG_INIT <= 1'b1; // [R13]
    end else begin
      PERIPH_REG_INIT <= 1'b0;
    end
  end

  // held at zero after reset; nothing here enables it
  always @(posedge REF_CLK) begin
    if (any_reset) begin
      WATCHDOG_ENABLE <= 1'b0; // [R13]
    end else begin
      WATCHDOG_ENABLE <= WATCHDOG_ENABLE;
    end
  end

  always @(posedge REF_CLK) begin
    if (any_reset) begin
      PORT_DIR_OUT <= `ALL_ZERO; // [R11]
    end else begin
      PORT_DIR_OUT <= PORT_DIR_OUT;
    end
  end

  // port one bits zero and one have no pull to enable
  always @(posedge REF_CLK) begin
    if (any_reset) begin
      PORT_ONE_PULL_UP <= `ALL_PULL & ~`PORT_ONE_NOPULL; // [R11]
    end else begin
      PORT_ONE_PULL_UP <= PORT_ONE_PULL_UP;
    end
  end
  ////////////////////////////////////////////////////////////////
  // deep sleep effects
  // clear pulse on sleep entry [R8]
  always @(posedge REF_CLK) begin
    if (any_reset) begin
      WATCHDOG_COUNT_CLEAR <= 1'b1;
    end else begin
      WATCHDOG_COUNT_CLEAR <= deep_entry;
    end
  end

  // registers survive; no reinit strobe in sleep [R7]
  always @(posedge REF_CLK) begin
    if (any_reset) begin
      REGISTERS_RETAINED <= 1'b0;
    end else begin
      REGISTERS_RETAINED <= 1'b1;
    end
  end

  // calibration back to default on wake [R9]
  always @(posedge REF_CLK) begin
    if (any_reset) begin
      RC_CAL_RESTORE <= 1'b1;
    end else begin
      RC_CAL_RESTORE <= deep_exit;
    end
  end

  // default sampled only on wake or reset, so a changing default is not tracked
  always @(posedge REF_CLK) begin
    if (any_reset) begin
      RC_CAL_VALUE <= RC_CAL_DEFAULT;
    end else begin
      if (deep_exit) begin
        RC_CAL_VALUE <= RC_CAL_DEFAULT;
      end else begin
        RC_CAL_VALUE <= RC_CAL_VALUE;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // memory retention classification
  // lost window taken out since it sits inside the kept range [R5] [R6]
  assign addr_lost = in_range(MEM_ADDR, `LOST_LO, `LOST_HI);
  assign addr_kept = in_range(MEM_ADDR, `RETAIN_LO, `RETAIN_HI) & ~addr_lost;

  always @(posedge REF_CLK) begin
    if (any_reset) begin
      MEM_ADDR_LOST <= 1'b0;
    end else begin
      MEM_ADDR_LOST <= addr_lost; // [R6]
    end
  end

  always @(posedge REF_CLK) begin
    if (any_reset) begin
      MEM_ADDR_RETAINED <= 1'b0;
    end else begin
      MEM_ADDR_RETAINED <= addr_kept; // [R5]
    end
  end

  // one cycle of latency on both flags keeps them glitch free
endmodule

// ==== verilog/tick_prescaler.v ====
`timescale 1ns/1ps
`include "rtr_consts.vh"
module tick_prescaler (
  input wire REF_CLK,
  input wire RESET,
  input wire [`TICK_DIV_W-1:0] DIV_SEL,
  output wire TICK
);
  reg [`TICK_CNT_W-1:0] count;
  reg [`TICK_CNT_W-1:0] mask;
  // divide by two to the power of the select value
  always @* begin
    mask = ({`TICK_CNT_W{1'b1}} >> (`TICK_CNT_W - DIV_SEL));
  end
  assign TICK = ((count & mask) == `TICK_CNT_ZERO);
  always @(posedge REF_CLK) begin
    if (RESET) begin
      count <= `TICK_CNT_ZERO;
    end else begin
      count <= count + `TICK_CNT_ONE;
    end
  end
endmodule
